// ---- rtl/daisy_comm_diag_counters.sv ----
// Design decision made here: register access over Wishbone.
`timescale 1ns/100ps
module daisy_comm_diag_counters (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [13:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic dir_sel,
  input wire logic upper_tx_en,
  input wire logic lower_tx_en,
  input wire diag_pkg::resp_evt_t upper_resp_evt,
  input wire diag_pkg::resp_evt_t lower_resp_evt,
  input wire diag_pkg::cmd_evt_t lower_cmd_evt,
  input wire diag_pkg::bit_evt_t lower_bit_evt,
  input wire diag_pkg::frame_evt_t host_frame_evt,
  input wire diag_pkg::frame_evt_t upper_frame_evt,
  input wire diag_pkg::frame_evt_t lower_frame_evt,
  input wire diag_pkg::otp_evt_t otp_evt,
  output logic frame_error_marker
);

  // ********************************************************
  // Bus decode
  // ********************************************************
  logic [11:0] idx;
  logic take;
  logic rd_take;
  logic [7:0] rd_byte;
  logic hit;

  // A request is taken once, at the edge before ack rises
  assign idx = wb_adr_i[13:2];
  assign take = clk_en && wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign rd_take = take && !wb_we_i;

  // Register file is read-only; writes and byte enables are ignored
  logic unused_wr;
  assign unused_wr = ^{wb_sel_i, wb_dat_i};

  // ********************************************************
  // Frame ignore state per port
  // ********************************************************
  logic host_ign_r;
  logic upper_ign_r;
  logic lower_ign_r;
  logic lower_halt;
  logic upper_halt;

  // Byte or init faults start ignoring until a comm clear
  assign lower_halt = lower_frame_evt.halt || lower_cmd_evt.init_fault
    || lower_cmd_evt.byte_fault || lower_resp_evt.byte_fault;
  assign upper_halt = upper_frame_evt.halt || upper_resp_evt.byte_fault;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      host_ign_r <= 1'b0;
      upper_ign_r <= 1'b0;
      lower_ign_r <= 1'b0;
    end else if (clk_en) begin
      host_ign_r <= host_frame_evt.clear ? 1'b0 : (host_ign_r || host_frame_evt.halt);
      upper_ign_r <= upper_frame_evt.clear ? 1'b0 : (upper_ign_r || upper_halt);
      lower_ign_r <= lower_frame_evt.clear ? 1'b0 : (lower_ign_r || lower_halt);
    end
  end

  // ********************************************************
  // Upper port response flags
  // ********************************************************
  logic [diag_pkg::RESP_W-1:0] up_set;
  logic [diag_pkg::RESP_W-1:0] up_flags;
  logic up_txdis;

  // Upper forwards responses only when direction is 0
  assign up_txdis = !dir_sel && upper_resp_evt.resp_rx && !upper_tx_en && !upper_ign_r;

  assign up_set[diag_pkg::B_WAIT] = upper_resp_evt.wait_pending && upper_resp_evt.cmd_rx;
  assign up_set[diag_pkg::B_TXDIS] = up_txdis;
  assign up_set[diag_pkg::B_SOF] = upper_resp_evt.sof_fault && !upper_ign_r;
  assign up_set[diag_pkg::B_BYTE] = (upper_resp_evt.byte_fault
    || upper_resp_evt.crc_byte_fault) && !upper_ign_r;
  assign up_set[diag_pkg::B_UNEXP] = dir_sel && upper_resp_evt.resp_rx && !upper_ign_r;
  assign up_set[diag_pkg::B_CRC] = (upper_resp_evt.crc_fail
    || upper_resp_evt.crc_byte_fault) && !upper_ign_r;

  flag_bank #(.W(diag_pkg::RESP_W)) u_up_resp (
    .clock(clock),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .set_i(up_set),
    .clr_i(rd_take && idx == diag_pkg::IDX_UPPER_RESP),
    .flags_q(up_flags)
  );

  // ********************************************************
  // Lower port response flags
  // ********************************************************
  logic [diag_pkg::RESP_W-1:0] lr_set;
  logic [diag_pkg::RESP_W-1:0] lr_flags;
  logic lr_txdis;

  assign lr_txdis = dir_sel && lower_resp_evt.resp_rx && !lower_tx_en && !lower_ign_r;

  assign lr_set[diag_pkg::B_WAIT] = lower_resp_evt.wait_pending && lower_resp_evt.cmd_rx;
  assign lr_set[diag_pkg::B_TXDIS] = lr_txdis;
  assign lr_set[diag_pkg::B_SOF] = lower_resp_evt.sof_fault && !lower_ign_r;
  assign lr_set[diag_pkg::B_BYTE] = (lower_resp_evt.byte_fault
    || lower_resp_evt.crc_byte_fault) && !lower_ign_r;
  assign lr_set[diag_pkg::B_UNEXP] = !dir_sel && lower_resp_evt.resp_rx && !lower_ign_r;
  assign lr_set[diag_pkg::B_CRC] = (lower_resp_evt.crc_fail
    || lower_resp_evt.crc_byte_fault) && !lower_ign_r;

  flag_bank #(.W(diag_pkg::RESP_W)) u_lr_resp (
    .clock(clock),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .set_i(lr_set),
    .clr_i(rd_take && idx == diag_pkg::IDX_LOWER_RESP),
    .flags_q(lr_flags)
  );

  // ********************************************************
  // Lower port command flags
  // ********************************************************
  logic [diag_pkg::RESP_W-1:0] lc_set;
  logic [diag_pkg::RESP_W-1:0] lc_flags;
  logic lc_txdis;

  // Commands arrive on the lower port when direction is 0
  assign lc_txdis = !dir_sel && lower_cmd_evt.cmd_rx && !lower_tx_en && !lower_ign_r;

  assign lc_set[diag_pkg::B_IERR] = lower_cmd_evt.init_fault && !lower_ign_r;
  assign lc_set[diag_pkg::B_TXDIS] = lc_txdis;
  assign lc_set[diag_pkg::B_SOF] = lower_cmd_evt.sof_fault && !lower_ign_r;
  assign lc_set[diag_pkg::B_BYTE] = lower_cmd_evt.byte_fault && !lower_ign_r;
  assign lc_set[diag_pkg::B_UNEXP] = dir_sel && lower_cmd_evt.cmd_rx && !lower_ign_r;
  assign lc_set[diag_pkg::B_CRC] = lower_cmd_evt.crc_fail && !lower_ign_r;

  flag_bank #(.W(diag_pkg::RESP_W)) u_lc_cmd (
    .clock(clock),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .set_i(lc_set),
    .clr_i(rd_take && idx == diag_pkg::IDX_LOWER_CMD),
    .flags_q(lc_flags)
  );

  // ********************************************************
  // Lower port bit-level flags and forwarded marker
  // ********************************************************
  logic [diag_pkg::BIT_W-1:0] lb_set;
  logic [diag_pkg::BIT_W-1:0] lb_flags;
  logic lb_abnormal;

  assign lb_set[diag_pkg::B_TAG] = lower_bit_evt.tagged_in && !lower_ign_r;
  assign lb_set[diag_pkg::B_LOSS] = lower_bit_evt.data_loss && !lower_ign_r;
  assign lb_set[diag_pkg::B_PRE] = lower_bit_evt.preamble_miss && !lower_ign_r;
  assign lb_set[diag_pkg::B_WEAK] = lower_bit_evt.weak_sample && !lower_ign_r;
  assign lb_abnormal = (|lb_set[diag_pkg::B_TAG:diag_pkg::B_WEAK])
    || (lower_bit_evt.anomaly && !lower_ign_r);
  assign lb_set[diag_pkg::B_ABN] = lb_abnormal;

  flag_bank #(.W(diag_pkg::BIT_W)) u_lb_bit (
    .clock(clock),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .set_i(lb_set),
    .clr_i(rd_take && idx == diag_pkg::IDX_LOWER_BIT),
    .flags_q(lb_flags)
  );

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      frame_error_marker <= 1'b0;
    end else if (clk_en) begin
      frame_error_marker <= lb_abnormal;
    end
  end

  // ********************************************************
  // Frame statistics per port
  // ********************************************************
  logic [7:0] host_disc;
  logic [7:0] upper_disc;
  logic [7:0] lower_disc;
  logic [15:0] host_valid;
  logic [15:0] upper_valid;
  logic [15:0] lower_valid;
  logic host_snap;
  logic upper_snap;
  logic lower_snap;

  assign host_snap = rd_take && idx == diag_pkg::IDX_HOST_DISC;
  assign upper_snap = rd_take && idx == diag_pkg::IDX_UPPER_DISC;
  assign lower_snap = rd_take && idx == diag_pkg::IDX_LOWER_DISC;

  frame_stats u_host_stats (
    .clock(clock),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .valid_i(host_frame_evt.valid && !host_ign_r),
    .discard_i(host_frame_evt.discard && !host_ign_r),
    .snap_i(host_snap),
    .run_disc_q(host_disc),
    .valid_q(host_valid)
  );

  frame_stats u_upper_stats (
    .clock(clock),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .valid_i(upper_frame_evt.valid && !upper_ign_r),
    .discard_i((upper_frame_evt.discard && !upper_ign_r) || up_txdis),
    .snap_i(upper_snap),
    .run_disc_q(upper_disc),
    .valid_q(upper_valid)
  );

  frame_stats u_lower_stats (
    .clock(clock),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .valid_i(lower_frame_evt.valid && !lower_ign_r),
    .discard_i((lower_frame_evt.discard && !lower_ign_r) || lr_txdis),
    .snap_i(lower_snap),
    .run_disc_q(lower_disc),
    .valid_q(lower_valid)
  );

  // ********************************************************
  // OTP error block capture
  // ********************************************************
  logic [7:0] otp_sec_blk_r;
  logic [7:0] otp_ded_blk_r;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      otp_sec_blk_r <= diag_pkg::RST_BYTE;
      otp_ded_blk_r <= diag_pkg::RST_BYTE;
    end else if (clk_en) begin
      if (otp_evt.sec) begin
        otp_sec_blk_r <= otp_evt.block;
      end
      if (otp_evt.ded) begin
        otp_ded_blk_r <= otp_evt.block;
      end
    end
  end

  // ********************************************************
  // Read mux and bus answer
  // ********************************************************
  // high and low bytes
  assign rd_byte =
    (idx == diag_pkg::IDX_UPPER_RESP) ? {2'b00, up_flags} :
    (idx == diag_pkg::IDX_LOWER_BIT) ? {3'b000, lb_flags} :
    (idx == diag_pkg::IDX_LOWER_CMD) ? {2'b00, lc_flags} :
    (idx == diag_pkg::IDX_LOWER_RESP) ? {2'b00, lr_flags} :
    (idx == diag_pkg::IDX_HOST_DISC) ? host_disc :
    (idx == diag_pkg::IDX_UPPER_DISC) ? upper_disc :
    (idx == diag_pkg::IDX_LOWER_DISC) ? lower_disc :
    (idx == diag_pkg::IDX_HOST_VHI) ? host_valid[15:8] :
    (idx == diag_pkg::IDX_HOST_VLO) ? host_valid[7:0] :
    (idx == diag_pkg::IDX_UPPER_VHI) ? upper_valid[15:8] :
    (idx == diag_pkg::IDX_UPPER_VLO) ? upper_valid[7:0] :
    (idx == diag_pkg::IDX_LOWER_VHI) ? lower_valid[15:8] :
    (idx == diag_pkg::IDX_LOWER_VLO) ? lower_valid[7:0] :
    (idx == diag_pkg::IDX_OTP_SEC) ? otp_sec_blk_r :
    (idx == diag_pkg::IDX_OTP_DED) ? otp_ded_blk_r : diag_pkg::RST_BYTE;
  assign hit = 1'b1;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= diag_pkg::RST_DATA;
    end else if (clk_en) begin
      wb_ack_o <= take && hit;
      if (rd_take) begin
        wb_dat_o <= {24'h00_0000, rd_byte};
      end
    end
  end

  // ********************************************************
  // Checks
  // ********************************************************
  property p_ack_once;
    @(posedge clock) disable iff (!rst_n)
      take |=> wb_ack_o ##1 (!wb_ack_o || !clk_en);
  endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack not single");

  property p_unexp;
    @(posedge clock) disable iff (!rst_n)
      (clk_en && !dir_sel && lower_resp_evt.resp_rx && !lower_ign_r) |=> lr_flags[diag_pkg::B_UNEXP];
  endproperty
  a_unexp: assert property (p_unexp) else $error("unexpected response missed");

  property p_txdis_count;
    @(posedge clock) disable iff (!rst_n)
      (clk_en && lr_txdis && !lower_snap && lower_disc != diag_pkg::DISC_MAX)
        |=> lr_flags[diag_pkg::B_TXDIS] && lower_disc == $past(lower_disc) + 8'h01;
  endproperty
  a_txdis_count: assert property (p_txdis_count) else $error("blocked forward not counted");

  property p_crc_byte;
    @(posedge clock) disable iff (!rst_n)
      (clk_en && lower_resp_evt.crc_byte_fault && !lower_ign_r)
        |=> lr_flags[diag_pkg::B_CRC] && lr_flags[diag_pkg::B_BYTE];
  endproperty
  a_crc_byte: assert property (p_crc_byte) else $error("checksum byte fault incomplete");

  sequence s_tag_seen;
    clk_en && lower_bit_evt.tagged_in && !lower_ign_r;
  endsequence
  property p_tag_abn;
    @(posedge clock) disable iff (!rst_n)
      s_tag_seen |=> frame_error_marker && lb_flags[diag_pkg::B_ABN] && lb_flags[diag_pkg::B_TAG];
  endproperty
  a_tag_abn: assert property (p_tag_abn) else $error("abnormal not raised");

  property p_ignore_hold;
    @(posedge clock) disable iff (!rst_n)
      (clk_en && lower_ign_r && !lower_snap && !lr_txdis) |=> $stable(lower_disc);
  endproperty
  a_ignore_hold: assert property (p_ignore_hold) else $error("ignored frame counted");

  property p_otp_ded;
    @(posedge clock) disable iff (!rst_n)
      (clk_en && otp_evt.ded) |=> otp_ded_blk_r == $past(otp_evt.block);
  endproperty
  a_otp_ded: assert property (p_otp_ded) else $error("block address not captured");

  property p_wait_abort;
    @(posedge clock) disable iff (!rst_n)
      (clk_en && upper_resp_evt.wait_pending && upper_resp_evt.cmd_rx) |=> up_flags[diag_pkg::B_WAIT];
  endproperty
  a_wait_abort: assert property (p_wait_abort) else $error("wait abort missed");

endmodule

// ---- rtl/diag_pkg.sv ----
package diag_pkg;

  // ********************************************************
  // Register indices (byte address is four times the index)
  // ********************************************************
  localparam logic [11:0] IDX_UPPER_RESP = 12'h785;
  localparam logic [11:0] IDX_LOWER_BIT = 12'h786;
  localparam logic [11:0] IDX_LOWER_CMD = 12'h787;
  localparam logic [11:0] IDX_LOWER_RESP = 12'h788;
  localparam logic [11:0] IDX_HOST_DISC = 12'h789;
  localparam logic [11:0] IDX_UPPER_DISC = 12'h78a;
  localparam logic [11:0] IDX_LOWER_DISC = 12'h78b;
  localparam logic [11:0] IDX_HOST_VHI = 12'h78c;
  localparam logic [11:0] IDX_HOST_VLO = 12'h78d;
  localparam logic [11:0] IDX_UPPER_VHI = 12'h78e;
  localparam logic [11:0] IDX_UPPER_VLO = 12'h78f;
  localparam logic [11:0] IDX_LOWER_VHI = 12'h790;
  localparam logic [11:0] IDX_LOWER_VLO = 12'h791;
  localparam logic [11:0] IDX_OTP_SEC = 12'h7a0;
  localparam logic [11:0] IDX_OTP_DED = 12'h7a1;

  // ********************************************************
  // Widths, reset values and limits
  // ********************************************************
  localparam int ADR_W = 14;
  localparam int RESP_W = 6;
  localparam int BIT_W = 5;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [15:0] VALID_MAX = 16'hffff;
  localparam logic [7:0] DISC_MAX = 8'hff;
  localparam logic [31:0] RST_DATA = 32'h0000_0000;

  // ********************************************************
  // Field positions
  // ********************************************************
  localparam int B_WAIT = 5;
  localparam int B_IERR = 5;
  localparam int B_TXDIS = 4;
  localparam int B_SOF = 3;
  localparam int B_BYTE = 2;
  localparam int B_UNEXP = 1;
  localparam int B_CRC = 0;
  localparam int B_ABN = 4;
  localparam int B_TAG = 3;
  localparam int B_LOSS = 2;
  localparam int B_PRE = 1;
  localparam int B_WEAK = 0;

  // ********************************************************
  // Event carriers (one-cycle pulses except wait_pending)
  // ********************************************************
  typedef struct packed {
    logic wait_pending;
    logic cmd_rx;
    logic resp_rx;
    logic sof_fault;
    logic byte_fault;
    logic crc_fail;
    logic crc_byte_fault;
  } resp_evt_t;

  typedef struct packed {
    logic init_fault;
    logic cmd_rx;
    logic sof_fault;
    logic byte_fault;
    logic crc_fail;
  } cmd_evt_t;

  typedef struct packed {
    logic tagged_in;
    logic data_loss;
    logic preamble_miss;
    logic weak_sample;
    logic anomaly;
  } bit_evt_t;

  typedef struct packed {
    logic valid;
    logic discard;
    logic halt;
    logic clear;
  } frame_evt_t;

  typedef struct packed {
    logic sec;
    logic ded;
    logic [7:0] block;
  } otp_evt_t;

endpackage

// ---- rtl/flag_bank.sv ----
`timescale 1ns/100ps
module flag_bank #(
  parameter int W = 6
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic [W-1:0] set_i,
  input wire logic clr_i,
  output logic [W-1:0] flags_q
);

  // Sticky flags, a set in the clearing cycle survives
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      flags_q <= '0;
    end else if (clk_en) begin
      flags_q <= (flags_q & ~{W{clr_i}}) | set_i;
    end
  end

  property p_set_wins;
    @(posedge clock) disable iff (!rst_n)
      (clk_en && set_i != '0) |=> ((flags_q & $past(set_i)) == $past(set_i));
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("flag set lost");

endmodule

// ---- rtl/frame_stats.sv ----
`timescale 1ns/100ps
module frame_stats (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic valid_i,
  input wire logic discard_i,
  input wire logic snap_i,
  output logic [7:0] run_disc_q,
  output logic [15:0] valid_q
);

  logic [15:0] run_valid_r;
  logic [15:0] run_valid_nxt;
  logic [7:0] run_disc_nxt;

  // Saturating increment used by both running counters
  // saturate, never wrap
  function automatic logic [15:0] sat_inc(input logic [15:0] v, input logic [15:0] lim);
    sat_inc = (v == lim) ? v : v + 16'h0001;
  endfunction

  // Snapshot restarts the count; an event in that cycle starts the new one
  assign run_valid_nxt = snap_i ? {15'h0000, valid_i}
    : (valid_i ? sat_inc(run_valid_r, diag_pkg::VALID_MAX) : run_valid_r);
  assign run_disc_nxt = snap_i ? {7'h00, discard_i}
    : (discard_i ? 8'(sat_inc({8'h00, run_disc_q}, {8'h00, diag_pkg::DISC_MAX})) : run_disc_q);

  // Running counters and latched valid count
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      run_valid_r <= diag_pkg::RST_WORD;
      run_disc_q <= diag_pkg::RST_BYTE;
      valid_q <= diag_pkg::RST_WORD;
    end else if (clk_en) begin
      run_valid_r <= run_valid_nxt;
      run_disc_q <= run_disc_nxt;
      if (snap_i) begin
        valid_q <= run_valid_r;
      end
    end
  end

  property p_valid_sat;
    @(posedge clock) disable iff (!rst_n)
      (clk_en && !snap_i && run_valid_r == diag_pkg::VALID_MAX) |=> run_valid_r == diag_pkg::VALID_MAX;
  endproperty
  a_valid_sat: assert property (p_valid_sat) else $error("valid counter wrapped");

  property p_snap_latch;
    @(posedge clock) disable iff (!rst_n)
      (clk_en && snap_i) |=> (valid_q == $past(run_valid_r)) && (run_valid_r <= 16'h0001);
  endproperty
  a_snap_latch: assert property (p_snap_latch) else $error("snapshot wrong");

  property p_disc_reset;
    @(posedge clock) disable iff (!rst_n)
      (clk_en && snap_i && !discard_i) |=> run_disc_q == diag_pkg::RST_BYTE;
  endproperty
  a_disc_reset: assert property (p_disc_reset) else $error("discard not reset");

endmodule

// ---- verification/link_partner.sv ----
`timescale 1ns/100ps
module link_partner (
  input wire logic clock,
  input wire logic go,
  input wire logic [1:0] port,
  input wire logic [16:0] n_valid,
  input wire logic [7:0] n_disc,
  input wire logic halt,
  input wire logic clear,
  output logic busy,
  output diag_pkg::frame_evt_t host_evt,
  output diag_pkg::frame_evt_t upper_evt,
  output diag_pkg::frame_evt_t lower_evt
);
  logic [16:0] v_r = '0;
  logic [7:0] d_r = '0;
  diag_pkg::frame_evt_t e_r = '0;
  // One frame per cycle: valid frames first, then discarded ones
  always_ff @(posedge clock) begin
    e_r <= {2'b00, halt, clear};
    if (go) begin
      v_r <= n_valid;
      d_r <= n_disc;
    end else if (v_r != '0) begin
      v_r <= v_r - 17'h0_0001;
      e_r.valid <= 1'b1;
    end else if (d_r != '0) begin
      d_r <= d_r - 8'h01;
      e_r.discard <= 1'b1;
    end
  end
  // Busy until the last pulse has been seen by the block
  assign busy = go || (v_r != '0) || (d_r != '0) || (e_r != '0);
  assign host_evt = (port == 2'd0) ? e_r : '0;
  assign upper_evt = (port == 2'd1) ? e_r : '0;
  assign lower_evt = (port == 2'd2) ? e_r : '0;
endmodule

// ---- verification/tb_daisy_comm_diag_counters.sv ----
`timescale 1ns/100ps
module tb_daisy_comm_diag_counters;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [13:0] adr = '0;
  logic [31:0] wdat = '0;
  logic dir_sel = 1'b0;
  logic lower_tx_en = 1'b0;
  logic go = 1'b0;
  logic halt = 1'b0;
  logic clear = 1'b0;
  logic [1:0] port = '0;
  logic [16:0] n_valid = '0;
  logic [7:0] n_disc = '0;
  diag_pkg::resp_evt_t resp_evt = '0;
  diag_pkg::bit_evt_t bit_evt = '0;
  diag_pkg::otp_evt_t otp_evt = '0;
  diag_pkg::frame_evt_t host_fe, upper_fe, lower_fe;
  logic [31:0] rdat;
  logic ack;
  logic marker;
  logic busy;
  int errors = 0;
  int n_compared = 0;

  // ********************
  // Block and partner
  // ********************
  daisy_comm_diag_counters uut (
    .clock(clock), .rst_n(rst_n), .clk_en(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .dir_sel(dir_sel), .upper_tx_en(1'b0), .lower_tx_en(lower_tx_en),
    .upper_resp_evt(resp_evt), .lower_resp_evt(resp_evt), .lower_cmd_evt('0),
    .lower_bit_evt(bit_evt), .host_frame_evt(host_fe), .upper_frame_evt(upper_fe),
    .lower_frame_evt(lower_fe), .otp_evt(otp_evt), .frame_error_marker(marker)
  );
  link_partner peer (
    .clock(clock), .go(go), .port(port), .n_valid(n_valid), .n_disc(n_disc),
    .halt(halt), .clear(clear), .busy(busy), .host_evt(host_fe), .upper_evt(upper_fe),
    .lower_evt(lower_fe)
  );

  // Clock generator
  always #25 clock = ~clock;

  task automatic stop_test();
    if (errors == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Classic single cycle, held until ack is sampled
  task automatic wb_rd(input logic [11:0] idx, input logic wr, output logic [31:0] d);
    @(posedge clock);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= wr;
    wdat <= {32{wr}};
    adr <= {idx, 2'b00};
    do begin
      @(posedge clock);
    end while (ack !== 1'b1);
    d = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic rd_chk(input logic [11:0] idx, input logic [31:0] exp);
    logic [31:0] d;
    wb_rd(idx, 1'b0, d);
    chk(d, exp);
  endtask

  // Writes each index in turn, then reads it back as zero
  task automatic t_regs();
    logic [31:0] d;
    logic [11:0] idx;
    for (int i = 0; i < 18; i++) begin
      idx = (i < 15) ? 12'(12'h785 + i) : 12'(12'h7a0 + i - 15);
      wb_rd(idx, 1'b1, d);
      rd_chk(idx, 32'h0000_0000);
    end
  endtask

  task automatic t_bits();
    diag_pkg::bit_evt_t ev [5] = '{5'h10, 5'h08, 5'h04, 5'h02, 5'h01};
    logic [7:0] ex [5] = '{8'h18, 8'h14, 8'h12, 8'h11, 8'h10};
    for (int i = 0; i < 5; i++) begin
      @(posedge clock);
      bit_evt <= ev[i];
      @(posedge clock);
      bit_evt <= '0;
      @(posedge clock);
      chk({31'h0, marker}, 32'h0000_0001);
      rd_chk(diag_pkg::IDX_LOWER_BIT, {24'h0, ex[i]});
      rd_chk(diag_pkg::IDX_LOWER_BIT, 32'h0000_0000);
    end
  endtask

  task automatic t_resp();
    diag_pkg::resp_evt_t ev [5] = '{7'h10, 7'h10, 7'h60, 7'h02, 7'h01};
    logic [7:0] ex [5] = '{8'h10, 8'h02, 8'h20, 8'h01, 8'h05};
    logic [7:0] ux [5] = '{8'h02, 8'h10, 8'h20, 8'h01, 8'h05};
    for (int i = 0; i < 5; i++) begin
      @(posedge clock);
      dir_sel <= (i != 1);
      @(posedge clock);
      resp_evt <= ev[i];
      @(posedge clock);
      resp_evt <= '0;
      rd_chk(diag_pkg::IDX_LOWER_RESP, {24'h0, ex[i]});
      rd_chk(diag_pkg::IDX_UPPER_RESP, {24'h0, ux[i]});
      if (i == 0) rd_chk(diag_pkg::IDX_LOWER_DISC, 32'h0000_0001);
    end
  endtask

  task automatic ctl(input logic h, input logic c);
    @(posedge clock);
    port <= 2'd2;
    halt <= h;
    clear <= c;
    @(posedge clock);
    halt <= 1'b0;
    clear <= 1'b0;
    repeat (2) @(posedge clock);
  endtask

  task automatic t_count(input logic [1:0] p, input logic [16:0] nv, input logic [7:0] nd,
                         input logic ig);
    logic [11:0] di;
    logic [11:0] vi;
    logic [15:0] v;
    logic [31:0] d;
    di = diag_pkg::IDX_HOST_DISC + {10'h0, p};
    vi = diag_pkg::IDX_HOST_VHI + {9'h0, p, 1'b0};
    v = ig ? 16'h0000 : (nv[16] ? 16'hffff : nv[15:0]);
    wb_rd(di, 1'b0, d);
    wb_rd(di, 1'b0, d);
    @(posedge clock);
    port <= p;
    n_valid <= nv;
    n_disc <= nd;
    go <= 1'b1;
    @(posedge clock);
    go <= 1'b0;
    do begin
      @(posedge clock);
    end while (busy === 1'b1);
    rd_chk(vi + 12'h001, 32'h0000_0000);
    rd_chk(di, {24'h0, ig ? 8'h00 : nd});
    rd_chk(vi, {24'h0, v[15:8]});
    rd_chk(vi + 12'h001, {24'h0, v[7:0]});
    rd_chk(di, 32'h0000_0000);
  endtask

  task automatic t_otp();
    @(posedge clock);
    otp_evt <= {1'b1, 1'b0, 8'h5a};
    @(posedge clock);
    otp_evt <= {1'b0, 1'b1, 8'ha5};
    @(posedge clock);
    otp_evt <= '0;
    rd_chk(diag_pkg::IDX_OTP_SEC, 32'h0000_005a);
    rd_chk(diag_pkg::IDX_OTP_DED, 32'h0000_00a5);
  endtask

  // Main sequence
  initial begin
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    t_regs();
    t_bits();
    t_resp();
    t_count(2'd0, 17'h0_0105, 8'h03, 1'b0);
    t_count(2'd1, 17'h0_0002, 8'h07, 1'b0);
    ctl(1'b1, 1'b0);
    t_count(2'd2, 17'h0_0003, 8'h02, 1'b1);
    ctl(1'b0, 1'b1);
    t_count(2'd2, 17'h1_0004, 8'hff, 1'b0);
    t_otp();
    stop_test();
  end

  // Watchdog against a hang
  initial begin
    repeat (90000) @(posedge clock);
    errors++;
    stop_test();
  end
endmodule
